//--- common/flash_ctrl_consts.vh
// Register offsets, field positions, reset values and erase block map for the flash sequencer
`ifndef FLASH_CTRL_CONSTS_VH
`define FLASH_CTRL_CONSTS_VH

// Byte offsets on the register bus
`define OFS_MODE_CONTROL 12'h000
`define OFS_ERROR_STATUS 12'h004
`define OFS_EBR_LOW 12'h008
`define OFS_EBR_HIGH 12'h00c
`define APB_ADDR_W 12

// Mode control fields
`define MC_PROGRAM 0
`define MC_ERASE 1
`define MC_PROGRAM_VERIFY 2
`define MC_ERASE_VERIFY 3
`define MC_PROGRAM_SETUP 4
`define MC_ERASE_SETUP 5
`define MC_SW_WRITE_ENABLE 6
`define MC_RESERVED 7

// Error status fields
`define ES_FLASH_ERROR_FLAG 7

// Reset values
`define RST_MODE_CONTROL 8'h00
`define RST_ERROR_STATUS 8'h00
`define RST_EBR_LOW 8'h00
`define RST_EBR_HIGH 2'h0

// Erase block count and widths
`define NUM_BLOCKS 10
`define EBR_HIGH_W 2
`define FLASH_ADDR_W 24

// Erase block base addresses
`define BLK0_BASE 24'h000000
`define BLK1_BASE 24'h000400
`define BLK2_BASE 24'h000800
`define BLK3_BASE 24'h000c00
`define BLK4_BASE 24'h001000
`define BLK5_BASE 24'h008000
`define BLK6_BASE 24'h00c000
`define BLK7_BASE 24'h00e000
`define BLK8_BASE 24'h010000
`define BLK9_BASE 24'h018000

// Erase block last addresses
`define BLK0_LAST 24'h0003ff
`define BLK1_LAST 24'h0007ff
`define BLK2_LAST 24'h000bff
`define BLK3_LAST 24'h000fff
`define BLK4_LAST 24'h007fff
`define BLK5_LAST 24'h00bfff
`define BLK6_LAST 24'h00dfff
`define BLK7_LAST 24'h00ffff
`define BLK8_LAST 24'h017fff
`define BLK9_LAST 24'h01ffff

`endif

//--- rtl/erase_block_decode.v
// Maps a one-hot erase block selection to the address range it covers
`timescale 1ns/1ps
`include "flash_ctrl_consts.vh"

module erase_block_decode #(
  parameter NUM_BLOCKS = `NUM_BLOCKS,
  parameter ADDR_W = `FLASH_ADDR_W
) (
  input wire [NUM_BLOCKS-1:0] select_in,
  output reg [ADDR_W-1:0] base_out,
  output reg [ADDR_W-1:0] last_out,
  output reg hit_out
);

  always @*
  begin
    hit_out = 1'b1;
    case (select_in)
      10'h001:
      begin
        base_out = `BLK0_BASE;
        last_out = `BLK0_LAST;
      end
      10'h002:
      begin
        base_out = `BLK1_BASE;
        last_out = `BLK1_LAST;
      end
      10'h004:
      begin
        base_out = `BLK2_BASE;
        last_out = `BLK2_LAST;
      end
      10'h008:
      begin
        base_out = `BLK3_BASE;
        last_out = `BLK3_LAST;
      end
      10'h010:
      begin
        base_out = `BLK4_BASE;
        last_out = `BLK4_LAST;
      end
      10'h020:
      begin
        base_out = `BLK5_BASE;
        last_out = `BLK5_LAST;
      end
      10'h040:
      begin
        base_out = `BLK6_BASE;
        last_out = `BLK6_LAST;
      end
      10'h080:
      begin
        base_out = `BLK7_BASE;
        last_out = `BLK7_LAST;
      end
      10'h100:
      begin
        base_out = `BLK8_BASE;
        last_out = `BLK8_LAST;
      end
      10'h200:
      begin
        base_out = `BLK9_BASE;
        last_out = `BLK9_LAST;
      end
      default:
      begin
        // None or several selected: no range at all
        base_out = {ADDR_W{1'b0}};
        last_out = {ADDR_W{1'b0}};
        hit_out = 1'b0;
      end
    endcase
  end

endmodule // erase_block_decode

//--- rtl/flash_program_erase_control.v
// Flash program/erase mode control, error status and erase block selection over APB
`timescale 1ns/1ps
`include "flash_ctrl_consts.vh"

// Behaviour
// - Program and erase are only possible while the write-enable bit is 1.
// - With write-enable 0, no other control bit or low select bit can be set.
// - Erase-setup bit 5 enters and leaves the erase setup state.
// - Erase bit 1 enters erase mode only with write-enable and erase-setup set.
// - Program-setup bit 4 enters and leaves the program setup state.
// - Program bit 0 enters program mode only with write-enable and program-setup set.
// - Erase-verify bit 3 enters and leaves erase-verify mode.
// - Program-verify bit 2 enters and leaves program-verify mode.
// - Mode control bit 7 always reads 0.
// - A fault during program or erase sets error flag bit 7.
// - While the error flag is 1, program and erase are blocked.
// - Error status bits 6 to 0 always read 0.
// - The low select register is all zeros while write-enable is 0.
// - More than one select bit set across both registers clears them all.
// - Low select bits 3 to 0 each pick one 1 Kbyte block from address 0.
// - Bits 4 to 7 pick the 28, 16, 8 and 8 Kbyte blocks.
// - High select bit 0 picks block at 010000, bit 1 at 018000, both 32 Kbytes.
module flash_program_erase_control #(
  parameter NUM_BLOCKS = `NUM_BLOCKS,
  parameter ADDR_W = `FLASH_ADDR_W
) (
  input wire clock_in,
  input wire resetn_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`APB_ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire flash_fault_in,
  output reg program_setup_out,
  output reg erase_setup_out,
  output reg program_mode_out,
  output reg erase_mode_out,
  output reg program_verify_out,
  output reg erase_verify_out,
  output reg error_protect_out,
  output reg [NUM_BLOCKS-1:0] erase_block_out,
  output reg erase_range_valid_out,
  output reg [ADDR_W-1:0] erase_base_out,
  output reg [ADDR_W-1:0] erase_last_out
);

  // APB slave states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SETUP = 3'b010;
  localparam [2:0] ST_ACCESS = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;

  // Mode control, error flag and erase block select bits
  reg sw_write_enable_r;
  reg erase_setup_r;
  reg program_setup_r;
  reg erase_verify_r;
  reg program_verify_r;
  reg erase_r;
  reg program_r;
  reg flash_error_flag_r;
  reg [7:0] erase_block_select_low_r;
  reg [`EBR_HIGH_W-1:0] erase_block_select_high_r;

  reg sw_write_enable_nxt;
  reg erase_setup_nxt;
  reg program_setup_nxt;
  reg erase_verify_nxt;
  reg program_verify_nxt;
  reg erase_nxt;
  reg program_nxt;
  reg flash_error_flag_nxt;
  reg [7:0] erase_block_select_low_nxt;
  reg [`EBR_HIGH_W-1:0] erase_block_select_high_nxt;
  reg [NUM_BLOCKS-1:0] sel_all_nxt;

  wire [NUM_BLOCKS-1:0] sel_all;
  wire [NUM_BLOCKS-1:0] active_sel;
  wire [ADDR_W-1:0] dec_base;
  wire [ADDR_W-1:0] dec_last;
  wire dec_hit;
  wire wr_commit;
  wire low_lane_wr;
  wire [7:0] wbyte;
  wire [7:0] mode_control_rd;
  wire [7:0] error_status_rd;

  // More than one bit set in a selection vector
  function more_than_one;
    input [NUM_BLOCKS-1:0] v;
    integer i;
    reg seen;
    reg multi;
    begin
      seen = 1'b0;
      multi = 1'b0;
      for (i = 0; i < NUM_BLOCKS; i = i + 1)
      begin
        multi = multi | (seen & v[i]);
        seen = seen | v[i];
      end
      more_than_one = multi;
    end
  endfunction

  // Whether an address maps to a register
  function addr_mapped;
    input [`APB_ADDR_W-1:0] a;
    begin
      addr_mapped = (a == `OFS_MODE_CONTROL) || (a == `OFS_ERROR_STATUS) ||
        (a == `OFS_EBR_LOW) || (a == `OFS_EBR_HIGH);
    end
  endfunction

  assign sel_all = {erase_block_select_high_r, erase_block_select_low_r};
  assign wbyte = pwdata_in[7:0];
  assign low_lane_wr = pstrb_in[0];
  // SETUP taken at the last edge, so this is the access cycle
  assign wr_commit = (state_r == ST_SETUP) && pready_out && psel_in && penable_in &&
    pwrite_in && low_lane_wr;

  assign mode_control_rd = {1'b0, sw_write_enable_r, erase_setup_r, program_setup_r,
    erase_verify_r, program_verify_r, erase_r, program_r};
  assign error_status_rd = {flash_error_flag_r, 7'h00};

  // Erase acts on one selected block only, never on none or several
  assign active_sel = (erase_r && !more_than_one(sel_all)) ? sel_all :
    {NUM_BLOCKS{1'b0}};

  erase_block_decode #(
    .NUM_BLOCKS(NUM_BLOCKS),
    .ADDR_W(ADDR_W)
  ) u_decode (
    .select_in(active_sel),
    .base_out(dec_base),
    .last_out(dec_last),
    .hit_out(dec_hit)
  );

  // Bus phase tracking
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        state_nxt = (psel_in && !penable_in) ? ST_SETUP : ST_IDLE;
      ST_SETUP:
        state_nxt = ST_ACCESS;
      ST_ACCESS:
        state_nxt = (psel_in && !penable_in) ? ST_SETUP : ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Register next values
  always @*
  begin
    sw_write_enable_nxt = sw_write_enable_r;
    erase_setup_nxt = erase_setup_r;
    program_setup_nxt = program_setup_r;
    erase_verify_nxt = erase_verify_r;
    program_verify_nxt = program_verify_r;
    erase_nxt = erase_r;
    program_nxt = program_r;
    flash_error_flag_nxt = flash_error_flag_r;
    erase_block_select_low_nxt = erase_block_select_low_r;
    erase_block_select_high_nxt = erase_block_select_high_r;
    sel_all_nxt = {NUM_BLOCKS{1'b0}};

    if (wr_commit && paddr_in == `OFS_MODE_CONTROL)
    begin
      sw_write_enable_nxt = wbyte[`MC_SW_WRITE_ENABLE];
      // Other bits only set while write-enable already holds 1
      erase_setup_nxt = wbyte[`MC_ERASE_SETUP] & sw_write_enable_r;
      program_setup_nxt = wbyte[`MC_PROGRAM_SETUP] & sw_write_enable_r;
      erase_verify_nxt = wbyte[`MC_ERASE_VERIFY] & sw_write_enable_r;
      program_verify_nxt = wbyte[`MC_PROGRAM_VERIFY] & sw_write_enable_r;
      erase_nxt = wbyte[`MC_ERASE] & sw_write_enable_r & erase_setup_r &
        !flash_error_flag_r;
      program_nxt = wbyte[`MC_PROGRAM] & sw_write_enable_r & program_setup_r &
        !flash_error_flag_r;
    end

    if (wr_commit && paddr_in == `OFS_EBR_LOW)
      erase_block_select_low_nxt = wbyte & {8{sw_write_enable_r}};
    if (wr_commit && paddr_in == `OFS_EBR_HIGH)
      erase_block_select_high_nxt = wbyte[`EBR_HIGH_W-1:0] &
        {`EBR_HIGH_W{sw_write_enable_r}};

    // Fault during an active operation; set wins, cleared only by reset
    if (flash_fault_in && (program_r || erase_r))
      flash_error_flag_nxt = 1'b1;

    // Error protection drops program and erase at once
    if (flash_error_flag_nxt)
    begin
      program_nxt = 1'b0;
      erase_nxt = 1'b0;
    end

    // Dropping write-enable ends every mode and empties the selection
    if (!sw_write_enable_nxt)
    begin
      erase_setup_nxt = 1'b0;
      program_setup_nxt = 1'b0;
      erase_verify_nxt = 1'b0;
      program_verify_nxt = 1'b0;
      erase_nxt = 1'b0;
      program_nxt = 1'b0;
      erase_block_select_low_nxt = 8'h00;
      erase_block_select_high_nxt = {`EBR_HIGH_W{1'b0}};
    end

    sel_all_nxt = {erase_block_select_high_nxt, erase_block_select_low_nxt};
    if (more_than_one(sel_all_nxt))
    begin
      erase_block_select_low_nxt = 8'h00;
      erase_block_select_high_nxt = {`EBR_HIGH_W{1'b0}};
    end
  end

  // State and registers
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      state_r <= ST_IDLE;
      sw_write_enable_r <= 1'b0;
      erase_setup_r <= 1'b0;
      program_setup_r <= 1'b0;
      erase_verify_r <= 1'b0;
      program_verify_r <= 1'b0;
      erase_r <= 1'b0;
      program_r <= 1'b0;
      flash_error_flag_r <= 1'b0;
      erase_block_select_low_r <= `RST_EBR_LOW;
      erase_block_select_high_r <= `RST_EBR_HIGH;
    end
    else
    begin
      state_r <= state_nxt;
      sw_write_enable_r <= sw_write_enable_nxt;
      erase_setup_r <= erase_setup_nxt;
      program_setup_r <= program_setup_nxt;
      erase_verify_r <= erase_verify_nxt;
      program_verify_r <= program_verify_nxt;
      erase_r <= erase_nxt;
      program_r <= program_nxt;
      flash_error_flag_r <= flash_error_flag_nxt;
      erase_block_select_low_r <= erase_block_select_low_nxt;
      erase_block_select_high_r <= erase_block_select_high_nxt;
    end
  end

  // Bus answer prepared in the setup cycle, shown through the access cycle
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
    else if (psel_in && !penable_in)
    begin
      pready_out <= 1'b1;
      pslverr_out <= !addr_mapped(paddr_in);
      prdata_out <= 32'h00000000;
      if (!pwrite_in)
      begin
        case (paddr_in)
          `OFS_MODE_CONTROL:
            prdata_out <= {24'h000000, mode_control_rd};
          `OFS_ERROR_STATUS:
            prdata_out <= {24'h000000, error_status_rd};
          `OFS_EBR_LOW:
            prdata_out <= {24'h000000, erase_block_select_low_r};
          `OFS_EBR_HIGH:
            prdata_out <= {30'h0, erase_block_select_high_r};
          default:
            prdata_out <= 32'h00000000;
        endcase
      end
    end
    else
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
  end

  // Flash-facing outputs
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      program_setup_out <= 1'b0;
      erase_setup_out <= 1'b0;
      program_mode_out <= 1'b0;
      erase_mode_out <= 1'b0;
      program_verify_out <= 1'b0;
      erase_verify_out <= 1'b0;
      error_protect_out <= 1'b0;
      erase_block_out <= {NUM_BLOCKS{1'b0}};
      erase_range_valid_out <= 1'b0;
      erase_base_out <= {ADDR_W{1'b0}};
      erase_last_out <= {ADDR_W{1'b0}};
    end
    else
    begin
      program_setup_out <= program_setup_r;
      erase_setup_out <= erase_setup_r;
      program_mode_out <= program_r & sw_write_enable_r & !flash_error_flag_r;
      erase_mode_out <= erase_r & sw_write_enable_r & !flash_error_flag_r;
      program_verify_out <= program_verify_r;
      erase_verify_out <= erase_verify_r;
      error_protect_out <= flash_error_flag_r;
      erase_block_out <= active_sel;
      erase_range_valid_out <= dec_hit;
      erase_base_out <= dec_base;
      erase_last_out <= dec_last;
    end
  end

endmodule // flash_program_erase_control

//--- tb/flash_ctrl_props.sv
// Port-level assertions for the flash program/erase control block
`timescale 1ns/1ps
`include "flash_ctrl_consts.vh"
module flash_ctrl_props #(
  parameter NUM_BLOCKS = `NUM_BLOCKS,
  parameter ADDR_W = `FLASH_ADDR_W
) (
  input wire clock_in,
  input wire resetn_in,
  input wire psel_in,
  input wire pwrite_in,
  input wire [`APB_ADDR_W-1:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire flash_fault_in,
  input wire program_setup_out,
  input wire erase_setup_out,
  input wire program_mode_out,
  input wire erase_mode_out,
  input wire error_protect_out,
  input wire [NUM_BLOCKS-1:0] erase_block_out,
  input wire [ADDR_W-1:0] erase_base_out,
  input wire [ADDR_W-1:0] erase_last_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  wire rd_mode = psel_in && pready_out && !pwrite_in && paddr_in == `OFS_MODE_CONTROL;
  wire rd_err = psel_in && pready_out && !pwrite_in && paddr_in == `OFS_ERROR_STATUS;
  // Fault seen while a program or erase bit was held
  sequence fault_taken;
    flash_fault_in ##1 (program_mode_out || erase_mode_out);
  endsequence
  AST_FAULT_FLAG: assert property (fault_taken |=>
    error_protect_out && !program_mode_out)
    else $error("fault in program or erase did not raise protection");
  AST_PROTECT_STICKY: assert property (error_protect_out |=> error_protect_out)
    else $error("protection dropped without reset");
  AST_PROTECT_BLOCKS: assert property (error_protect_out |->
    !program_mode_out && !erase_mode_out)
    else $error("program or erase active under protection");
  AST_PROG_NEEDS_SETUP: assert property ($rose(program_mode_out) |->
    $past(program_setup_out))
    else $error("program mode entered without program setup");
  AST_ERASE_NEEDS_SETUP: assert property ($rose(erase_mode_out) |->
    $past(erase_setup_out))
    else $error("erase mode entered without erase setup");
  AST_MODE_RSVD: assert property (rd_mode |-> prdata_out[31:7] == 25'h0)
    else $error("mode control reserved bit read as 1");
  AST_GATED_READ: assert property (rd_mode && !prdata_out[6] |-> prdata_out == 32'h0)
    else $error("mode bit set while write enable is 0");
  AST_ERR_RSVD: assert property (rd_err |->
    prdata_out[6:0] == 7'h0 && prdata_out[31:8] == 24'h0)
    else $error("error status reserved bits not 0");
  AST_ONE_BLOCK: assert property (erase_block_out != 0 |-> $onehot(erase_block_out))
    else $error("more than one block selected for erase");
  AST_BLK3: assert property (erase_block_out == 10'h008 |->
    erase_base_out == 24'h000c00 && erase_last_out == 24'h000fff)
    else $error("block 3 range wrong");
  AST_BLK4: assert property (erase_block_out == 10'h010 |->
    erase_base_out == 24'h001000 && erase_last_out == 24'h007fff)
    else $error("block 4 range wrong");
  AST_BLK9: assert property (erase_block_out == 10'h200 |->
    erase_base_out == 24'h018000 && erase_last_out == 24'h01ffff)
    else $error("block 9 range wrong");
endmodule // flash_ctrl_props

//--- tb/tb_flash_program_erase_control.sv
// Self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
`include "flash_ctrl_consts.vh"
module tb_flash_program_erase_control;
  localparam NB = `NUM_BLOCKS;
  localparam AW = `FLASH_ADDR_W;
  logic clock_in = 0;
  logic resetn_in = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic fault = 0;
  logic [3:0] pstrb = 4'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, program_setup, erase_setup, pm, em, pvf, evf, eprot, rvalid;
  wire [NB-1:0] blk;
  wire [AW-1:0] base, last;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] r;
  logic e;
  logic [23:0] bt [0:9] = '{24'h000000, 24'h000400, 24'h000800, 24'h000c00, 24'h001000,
    24'h008000, 24'h00c000, 24'h00e000, 24'h010000, 24'h018000};
  logic [23:0] lt [0:9] = '{24'h0003ff, 24'h0007ff, 24'h000bff, 24'h000fff, 24'h007fff,
    24'h00bfff, 24'h00dfff, 24'h00ffff, 24'h017fff, 24'h01ffff};
  always #10 clock_in = ~clock_in;
  flash_program_erase_control dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .flash_fault_in(fault), .program_setup_out(program_setup), .erase_setup_out(erase_setup),
    .program_mode_out(pm), .erase_mode_out(em), .program_verify_out(pvf),
    .erase_verify_out(evf), .error_protect_out(eprot), .erase_block_out(blk),
    .erase_range_valid_out(rvalid), .erase_base_out(base), .erase_last_out(last));
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    pen <= 1'b1;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, r, x);
  endtask
  task settle;
    repeat (2) @(posedge clock_in);
  endtask
  task pulse_fault;
    @(posedge clock_in);
    fault <= 1'b1;
    @(posedge clock_in);
    fault <= 1'b0;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd("mode rst", `OFS_MODE_CONTROL, 32'h0);
    rd("err rst", `OFS_ERROR_STATUS, 32'h0);
    rd("low rst", `OFS_EBR_LOW, 32'h0);
    rd("high rst", `OFS_EBR_HIGH, 32'h0);
    wr(`OFS_MODE_CONTROL, 32'h3f);
    wr(`OFS_EBR_LOW, 32'h01);
    rd("mode gated", `OFS_MODE_CONTROL, 32'h0);
    rd("low gated", `OFS_EBR_LOW, 32'h0);
    wr(`OFS_MODE_CONTROL, 32'hff);
    rd("mode we only", `OFS_MODE_CONTROL, 32'h40);
    wr(`OFS_MODE_CONTROL, 32'h43);
    settle;
    chk("no setup", {pm, em}, 2'b00);
    $display("test gating done");
    wr(`OFS_MODE_CONTROL, 32'h50);
    settle;
    chk("prog setup", program_setup, 1'b1);
    wr(`OFS_MODE_CONTROL, 32'h51);
    settle;
    chk("prog mode", pm, 1'b1);
    wr(`OFS_MODE_CONTROL, 32'h40);
    settle;
    chk("prog off", {program_setup, pm}, 2'b00);
    wr(`OFS_MODE_CONTROL, 32'h44);
    settle;
    chk("pv on", pvf, 1'b1);
    wr(`OFS_MODE_CONTROL, 32'h48);
    settle;
    chk("ev on", {pvf, evf}, 2'b01);
    wr(`OFS_MODE_CONTROL, 32'h40);
    settle;
    chk("ev off", evf, 1'b0);
    $display("test program and verify done");
    wr(`OFS_MODE_CONTROL, 32'h60);
    wr(`OFS_MODE_CONTROL, 32'h62);
    for (int i = 0; i < NB; i++)
    begin
      wr(`OFS_EBR_LOW, 32'h0);
      wr(`OFS_EBR_HIGH, 32'h0);
      if (i < 8)
        wr(`OFS_EBR_LOW, 32'h1 << i);
      else
        wr(`OFS_EBR_HIGH, 32'h1 << (i - 8));
      settle;
      chk("block sel", blk, 32'h1 << i);
      chk("block base", base, bt[i]);
      chk("block last", last, lt[i]);
      chk("erase state", {em, erase_setup, rvalid}, 3'b111);
    end
    wr(`OFS_EBR_HIGH, 32'h0);
    settle;
    chk("no block", {blk, rvalid}, 32'h0);
    wr(`OFS_EBR_LOW, 32'h01);
    wr(`OFS_EBR_HIGH, 32'h01);
    rd("multi low", `OFS_EBR_LOW, 32'h0);
    rd("multi high", `OFS_EBR_HIGH, 32'h0);
    wr(`OFS_MODE_CONTROL, 32'h60);
    settle;
    chk("erase off", {em, erase_setup}, 2'b01);
    wr(`OFS_MODE_CONTROL, 32'h40);
    settle;
    chk("esu off", erase_setup, 1'b0);
    pstrb <= 4'h0;
    wr(`OFS_EBR_LOW, 32'h20);
    pstrb <= 4'h1;
    rd("strobe off", `OFS_EBR_LOW, 32'h0);
    wr(`OFS_EBR_LOW, 32'h20);
    wr(`OFS_MODE_CONTROL, 32'h00);
    rd("low cleared", `OFS_EBR_LOW, 32'h0);
    rd("mode cleared", `OFS_MODE_CONTROL, 32'h0);
    $display("test erase done");
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    apb(1'b1, 12'h010, 32'h80);
    chk("unmapped wr err", {31'h0, e}, 32'h1);
    rd("err no write", `OFS_ERROR_STATUS, 32'h0);
    wr(`OFS_MODE_CONTROL, 32'h40);
    wr(`OFS_MODE_CONTROL, 32'h50);
    pulse_fault;
    rd("fault ignored", `OFS_ERROR_STATUS, 32'h0);
    wr(`OFS_MODE_CONTROL, 32'h51);
    settle;
    pulse_fault;
    settle;
    chk("protected", {eprot, pm}, 2'b10);
    rd("err flag", `OFS_ERROR_STATUS, 32'h80);
    wr(`OFS_MODE_CONTROL, 32'h51);
    settle;
    chk("prog blocked", pm, 1'b0);
    rd("mode blocked", `OFS_MODE_CONTROL, 32'h50);
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd("err after rst", `OFS_ERROR_STATUS, 32'h0);
    $display("test fault done");
    print_verdict;
  end
endmodule // tb_flash_program_erase_control
bind flash_program_erase_control flash_ctrl_props #(.NUM_BLOCKS(NUM_BLOCKS), .ADDR_W(ADDR_W))
  u_props (.clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .flash_fault_in(flash_fault_in),
  .program_setup_out(program_setup_out), .erase_setup_out(erase_setup_out),
  .program_mode_out(program_mode_out), .erase_mode_out(erase_mode_out),
  .error_protect_out(error_protect_out), .erase_block_out(erase_block_out),
  .erase_base_out(erase_base_out), .erase_last_out(erase_last_out));
